//--- dzdq_dequantizer.sv
// deadzone scalar dequantizer for irreversible wavelet coefficients
// assumes a parser that loads per-subband factors and streams indices,
// and a synthesis stage that drains reconstructed values with valid/ready
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - deadzone width is two times (one minus factor) times the step size
// - factor equals signed numerator divided by two to the fifteenth
// - expounded uses each subband's factor; derived uses the lowpass factor everywhere
// - without extended quantization markers the factor is zero for all subbands
// - nonzero index: step times (index plus scaled rounding minus factor), signs mirrored
// - variable deadzone applies only to irreversible filters, never to the reversible path
module dzdq_dequantizer #(
  parameter int unsigned NUM_BANDS = dzdq_pkg::DEF_BANDS,
  parameter int unsigned INDEX_W   = dzdq_pkg::DEF_INDEX_W,
  parameter int unsigned STEP_W    = dzdq_pkg::DEF_STEP_W,
  parameter int unsigned PLANE_W   = dzdq_pkg::DEF_PLANE_W,
  parameter int unsigned BAND_W    = $clog2(NUM_BANDS),
  parameter int unsigned VAL_W     = INDEX_W + dzdq_pkg::FACTOR_FRAC + (1 << PLANE_W) + 2,
  parameter int unsigned COEF_W    = VAL_W + STEP_W + 1
) (
  // clock, reset, enable
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  input  wire logic                          ce_in,
  // component configuration
  input  wire dzdq_pkg::dzdq_mode_t          mode_in,
  input  wire logic                          irreversible_in,
  // factor loading
  input  wire logic                          factor_write_in,
  input  wire logic [BAND_W-1:0]             factor_band_in,
  input  wire logic signed [dzdq_pkg::FACTOR_W-1:0] deadzone_numerator_in,
  // index stream
  input  wire logic                          index_valid_in,
  output logic                               index_ready_out,
  input  wire logic signed [INDEX_W-1:0]     index_in,
  input  wire logic [BAND_W-1:0]             band_in,
  input  wire logic [STEP_W-1:0]             step_in,
  input  wire logic [dzdq_pkg::FACTOR_FRAC-1:0] rounding_in,
  input  wire logic [PLANE_W-1:0]            undecoded_planes_in,
  // reconstructed stream
  output logic                               coef_valid_out,
  input  wire logic                          coef_ready_in,
  output logic signed [COEF_W-1:0]           reconstructed_coefficient_out
);

  localparam int unsigned FW   = dzdq_pkg::FACTOR_W;
  localparam int unsigned FRAC = dzdq_pkg::FACTOR_FRAC;

  typedef struct packed {
    logic [NUM_BANDS-1:0][FW-1:0] factor;
  } dzdq_state_t;

  dzdq_state_t              state;
  dzdq_state_t              next_state;
  logic signed [FW-1:0]     deadzone_factor;
  logic signed [FW-1:0]     lowpass_deadzone_factor;
  logic [INDEX_W:0]         magnitude;
  logic signed [VAL_W-1:0]  v_mag;
  logic signed [VAL_W-1:0]  v_rnd;
  logic signed [VAL_W-1:0]  v_fac;
  logic signed [VAL_W-1:0]  level;
  logic signed [COEF_W-1:0] product;
  logic signed [COEF_W-1:0] coef;
  logic signed [COEF_W-1:0] half_deadzone;
  logic                     push;

  dzdq_stream_if #(.WIDTH(COEF_W)) to_buf ();
  dzdq_stream_if #(.WIDTH(COEF_W)) from_buf ();

  // ---------------------------------------------------------------
  // factor table
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (factor_write_in) begin
      next_state.factor[factor_band_in] = deadzone_numerator_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_BANDS; i++) begin
        state.factor[i] <= dzdq_pkg::FACTOR_RESET;
      end
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // factor selection
  // ---------------------------------------------------------------
  assign lowpass_deadzone_factor = $signed(state.factor[0]);

  always_comb begin
    deadzone_factor = dzdq_pkg::FACTOR_RESET;
    if (irreversible_in) begin
      unique case (mode_in)
        dzdq_pkg::DZDQ_MODE_EXPOUNDED: deadzone_factor = $signed(state.factor[band_in]);
        dzdq_pkg::DZDQ_MODE_DERIVED:   deadzone_factor = lowpass_deadzone_factor;
        dzdq_pkg::DZDQ_MODE_ABSENT:    deadzone_factor = dzdq_pkg::FACTOR_RESET;
        default:                       deadzone_factor = dzdq_pkg::FACTOR_RESET;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // reconstruction, all terms carry FRAC fractional bits
  // ---------------------------------------------------------------
  always_comb begin
    magnitude = index_in[INDEX_W-1] ? (INDEX_W+1)'(-$signed({index_in[INDEX_W-1], index_in}))
                                    : {1'b0, index_in};
    v_mag   = VAL_W'({magnitude, {FRAC{1'b0}}});
    v_rnd   = VAL_W'(rounding_in) <<< undecoded_planes_in;
    v_fac   = VAL_W'(deadzone_factor);
    level   = v_mag + v_rnd - v_fac;
    product = COEF_W'(level) * COEF_W'($signed({1'b0, step_in}));
    if (index_in == '0) begin
      coef = '0;
    end else if (index_in[INDEX_W-1]) begin
      coef = -product;
    end else begin
      coef = product;
    end
    // half of the deadzone width: (one minus factor) times step
    half_deadzone = COEF_W'($signed({1'b0, dzdq_pkg::FACTOR_ONE}) - (FW+2)'(deadzone_factor))
                    * COEF_W'($signed({1'b0, step_in}));
  end

  // ---------------------------------------------------------------
  // output buffer
  // ---------------------------------------------------------------
  assign to_buf.valid   = index_valid_in;
  assign to_buf.data    = coef;
  assign index_ready_out = to_buf.ready;
  assign push           = to_buf.valid && to_buf.ready;

  dzdq_skid_buffer #(
    .WIDTH(COEF_W)
  ) u_buffer (
    .clk_in  (clk_in),
    .reset_in(reset_in),
    .ce_in   (ce_in),
    .fill    (to_buf),
    .drain   (from_buf)
  );

  assign coef_valid_out                = from_buf.valid;
  assign from_buf.ready                = coef_ready_in;
  assign reconstructed_coefficient_out = $signed(from_buf.data);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  AST_DEADZONE_EDGE_POS: assert property (
    push && index_in == INDEX_W'(1) && rounding_in == '0 |-> coef == half_deadzone)
    else $error("first positive level is not half the deadzone width");

  AST_DEADZONE_EDGE_NEG: assert property (
    push && index_in == -INDEX_W'(1) && rounding_in == '0 |-> coef == -half_deadzone)
    else $error("first negative level is not minus half the deadzone width");

  AST_FACTOR_LOADED: assert property (
    ce_in && factor_write_in ##1 ce_in && irreversible_in
      && mode_in == dzdq_pkg::DZDQ_MODE_EXPOUNDED && band_in == $past(factor_band_in)
      |-> deadzone_factor == $past(deadzone_numerator_in))
    else $error("loaded numerator not used as factor");

  AST_DERIVED_USES_LOWPASS: assert property (
    irreversible_in && mode_in == dzdq_pkg::DZDQ_MODE_DERIVED
      |-> deadzone_factor == $signed(state.factor[0]))
    else $error("derived mode ignored the lowpass factor");

  AST_ABSENT_IS_ZERO: assert property (
    mode_in == dzdq_pkg::DZDQ_MODE_ABSENT |-> deadzone_factor == '0)
    else $error("factor nonzero without extended markers");

  AST_REVERSIBLE_PLAIN: assert property (
    !irreversible_in |-> deadzone_factor == '0)
    else $error("variable deadzone used on reversible path");

  AST_SIGN_FOLLOWS_INDEX: assert property (
    push && step_in != '0 && index_in != '0
      |-> (coef > 0) == !index_in[INDEX_W-1] && coef != 0)
    else $error("reconstructed sign disagrees with index");

  AST_ZERO_INDEX_OUT: assert property (
    push && index_in == '0 && !coef_valid_out && coef_ready_in && ce_in
      ##1 ce_in |-> coef_valid_out && reconstructed_coefficient_out == '0)
    else $error("zero index did not give zero one cycle later");

  AST_POS_OUTSIDE_DEADZONE: assert property (
    push && index_in != '0 && !index_in[INDEX_W-1] |-> coef >= half_deadzone)
    else $error("positive level falls inside the deadzone");

  AST_NEG_OUTSIDE_DEADZONE: assert property (
    push && index_in[INDEX_W-1] |-> coef <= -half_deadzone)
    else $error("negative level falls inside the deadzone");

  AST_BUFFER_KEEPS_PRECISION: assert property (
    push && !coef_valid_out && ce_in ##1 ce_in
      |-> reconstructed_coefficient_out == $past(coef))
    else $error("buffered coefficient differs from the computed one");

  AST_HALT_FREEZES_TABLE: assert property (
    !ce_in |=> $stable(state))
    else $error("factor table changed while halted");

  AST_HALT_NO_HANDSHAKE: assert property (
    !ce_in
      |-> !index_ready_out && !coef_valid_out)
    else $error("handshake active while halted");

  COV_NEGATIVE_INDEX: cover property (push && index_in[INDEX_W-1]);
  COV_DERIVED_MODE:   cover property (push && mode_in == dzdq_pkg::DZDQ_MODE_DERIVED);
  COV_STALL:          cover property (coef_valid_out && !coef_ready_in ##1 coef_valid_out);

endmodule : dzdq_dequantizer

`default_nettype wire

//--- dzdq_pkg.sv
// constants and types shared by the deadzone dequantizer files
// assumes a single clock domain and a parser that supplies fixed-point operands
package dzdq_pkg;

  // ---------------------------------------------------------------
  // fixed-point format of the deadzone factor
  // ---------------------------------------------------------------
  localparam int unsigned FACTOR_FRAC  = 15;
  localparam int unsigned FACTOR_W     = 16;
  localparam logic signed [FACTOR_W-1:0] FACTOR_RESET = 16'sh0000;
  localparam logic [FACTOR_W:0] FACTOR_ONE = 17'h08000;

  // ---------------------------------------------------------------
  // default datapath sizes
  // ---------------------------------------------------------------
  localparam int unsigned DEF_BANDS    = 64;
  localparam int unsigned DEF_INDEX_W  = 16;
  localparam int unsigned DEF_STEP_W   = 16;
  localparam int unsigned DEF_PLANE_W  = 4;

  // ---------------------------------------------------------------
  // how the deadzone factors are signalled
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DZDQ_MODE_ABSENT,
    DZDQ_MODE_EXPOUNDED,
    DZDQ_MODE_DERIVED
  } dzdq_mode_t;

endpackage : dzdq_pkg

//--- dzdq_stream_if.sv
// valid/ready stream carrier between the dequantizer and its output buffer
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none

interface dzdq_stream_if #(
  parameter int unsigned WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dzdq_stream_if

`default_nettype wire

//--- dzdq_skid_buffer.sv
// two-entry buffer with valid/ready on both sides and registered data out
// assumes clk_in, synchronous active-high reset_in and a clock enable
`timescale 1ns/1ps
`default_nettype none

module dzdq_skid_buffer #(
  parameter int unsigned WIDTH = 8
) (
  // clock, reset, enable
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic ce_in,
  // streams
  dzdq_stream_if.snk fill,
  dzdq_stream_if.src drain
);

  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic [1:0]       count;
  } dzdq_buf_state_t;

  dzdq_buf_state_t state;
  dzdq_buf_state_t next_state;
  logic            push;
  logic            pop;

  assign fill.ready  = ce_in && (state.count != 2'h2);
  assign drain.valid = ce_in && (state.count != 2'h0);
  assign drain.data  = state.head;
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  // ---------------------------------------------------------------
  // occupancy update
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case ({push, pop})
      2'b10: begin
        if (state.count == 2'h0) begin
          next_state.head = fill.data;
        end else begin
          next_state.tail = fill.data;
        end
        next_state.count = state.count + 2'h1;
      end
      2'b01: begin
        next_state.head  = state.tail;
        next_state.count = state.count - 2'h1;
      end
      2'b11: begin
        // one in, one out: the head moves on
        next_state.head = (state.count == 2'h1) ? fill.data : state.tail;
        next_state.tail = fill.data;
      end
      2'b00: begin
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= '0;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  AST_STALL_HOLDS_DATA: assert property (
    drain.valid && !drain.ready && ce_in |=> ce_in |-> $stable(drain.data) && drain.valid)
    else $error("buffered word changed while stalled");

  COV_BUFFER_FULL: cover property (state.count == 2'h2);

endmodule : dzdq_skid_buffer

`default_nettype wire

//--- dzdq_sink_model.sv
// downstream synthesis stand-in: takes reconstructed words, stalls on command
// assumes the dequantizer's valid/ready output stream, sampled on clk_in
`timescale 1ns/1ps
`default_nettype none

module dzdq_sink_model #(
  parameter int unsigned W = 66
) (
  // clock
  input  wire logic         clk_in,
  // pacing from the bench
  input  wire logic         hold_in,
  input  wire logic         slow_in,
  // stream
  input  wire logic         valid_in,
  input  wire logic [W-1:0] data_in,
  output logic              ready_out
);
  logic         tick = 1'b0;
  logic [W-1:0] rx_q[$];

  // slow pacing accepts on every other cycle only
  assign ready_out = !hold_in && (!slow_in || tick);

  always @(posedge clk_in) begin
    tick <= !tick;
    if (valid_in && ready_out) begin
      rx_q.push_back(data_in);
    end
  end
endmodule : dzdq_sink_model

`default_nettype wire

//--- test_deadzone_dequantizer.sv
// self-checking bench for the deadzone dequantizer
// assumes the design files and dzdq_sink_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module test_deadzone_dequantizer;
  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  logic                      clk_in = 1'b0, reset_in = 1'b1, ce_in = 1'b1;
  logic                      irreversible_in = 1'b1, factor_write_in = 1'b0;
  logic                      index_valid_in = 1'b0, hold = 1'b0, slow = 1'b0;
  dzdq_pkg::dzdq_mode_t      mode_in = dzdq_pkg::DZDQ_MODE_ABSENT;
  logic [5:0]                factor_band_in = 6'h00, band_in = 6'h00;
  logic signed [15:0]        deadzone_numerator_in = 16'sh0000, index_in = 16'sh0000;
  logic [15:0]               step_in = 16'h0000;
  logic [14:0]               rounding_in = 15'h0000;
  logic [3:0]                planes = 4'h0;
  logic                      index_ready, coef_valid, coef_ready;
  logic signed [65:0]        coef;
  logic signed [15:0]        fac[64];
  logic signed [65:0]        exp_q[$];
  dzdq_pkg::dzdq_mode_t      m_s = dzdq_pkg::DZDQ_MODE_ABSENT;
  logic                      i_s = 1'b1;
  int                        err_total = 0, samples_checked = 0, cyc = 0;

  dzdq_dequantizer i_dzdq_dequantizer (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .mode_in(mode_in), .irreversible_in(irreversible_in), .factor_write_in(factor_write_in),
    .factor_band_in(factor_band_in), .deadzone_numerator_in(deadzone_numerator_in),
    .index_valid_in(index_valid_in), .index_ready_out(index_ready), .index_in(index_in),
    .band_in(band_in), .step_in(step_in), .rounding_in(rounding_in),
    .undecoded_planes_in(planes), .coef_valid_out(coef_valid), .coef_ready_in(coef_ready),
    .reconstructed_coefficient_out(coef));

  dzdq_sink_model #(.W(66)) i_dzdq_sink_model (.clk_in(clk_in), .hold_in(hold), .slow_in(slow),
    .valid_in(coef_valid), .data_in(coef), .ready_out(coef_ready));

  initial forever #2 clk_in = !clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail

  task automatic close_out();
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic wfac(input logic [5:0] b, input logic signed [15:0] n);
    index_valid_in <= 1'b0;
    factor_write_in <= 1'b1;
    factor_band_in <= b;
    band_in <= b;
    deadzone_numerator_in <= n;
    fac[b] = n;
    @(posedge clk_in);
    factor_write_in <= 1'b0;
    @(posedge clk_in);
  endtask : wfac

  task automatic setmode(input dzdq_pkg::dzdq_mode_t m, input logic irr);
    mode_in <= m;
    irreversible_in <= irr;
    m_s = m;
    i_s = irr;
    @(posedge clk_in);
  endtask : setmode

  task automatic offer(input logic signed [15:0] q, input logic [5:0] b, input logic [15:0] s,
                       input logic [14:0] r, input logic [3:0] p);
    logic signed [65:0] n, t, mag, rr;
    n = 66'sh0;
    if (i_s && m_s == dzdq_pkg::DZDQ_MODE_EXPOUNDED) n = fac[b];
    if (i_s && m_s == dzdq_pkg::DZDQ_MODE_DERIVED) n = fac[0];
    mag = (q < 0) ? -q : q;
    rr = {51'h0, r};
    t = ((mag <<< 15) + (rr << p) - n) * $signed({50'h0, s});
    exp_q.push_back(q > 0 ? t : (q < 0 ? -t : 66'sh0));
    index_valid_in <= 1'b1;
    index_in <= q;
    band_in <= b;
    step_in <= s;
    rounding_in <= r;
    planes <= p;
  endtask : offer

  task automatic wait_take();
    @(negedge clk_in);
    while (index_ready !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
  endtask : wait_take

  task automatic send(input logic signed [15:0] q, input logic [5:0] b, input logic [15:0] s,
                      input logic [14:0] r, input logic [3:0] p);
    offer(q, b, s, r, p);
    wait_take();
  endtask : send

  task automatic drain();
    int k;
    k = 0;
    index_valid_in <= 1'b0;
    while (i_dzdq_sink_model.rx_q.size() < exp_q.size() && k < 100) begin
      @(negedge clk_in);
      k++;
    end
    while (exp_q.size() > 0) begin
      samples_checked++;
      if (i_dzdq_sink_model.rx_q.size() == 0) fail("coefficient missing");
      else if (i_dzdq_sink_model.rx_q.pop_front() !== exp_q.pop_front()) fail("bad value");
    end
    samples_checked++;
    if (i_dzdq_sink_model.rx_q.size() != 0) fail("extra coefficient");
    @(posedge clk_in);
  endtask : drain

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_expounded();
    setmode(dzdq_pkg::DZDQ_MODE_EXPOUNDED, 1'b1);
    send(16'sh0005, 6'h07, 16'h0100, 15'h0000, 4'h0);
    wfac(6'h03, 16'sh4000);
    wfac(6'h05, 16'sh8000);
    wfac(6'h00, 16'sh7fff);
    send(16'sh0003, 6'h03, 16'h0123, 15'h4000, 4'h2);
    send(-16'sh0003, 6'h03, 16'h0123, 15'h4000, 4'h2);
    send(16'sh0000, 6'h03, 16'h0123, 15'h4000, 4'h2);
    send(16'sh0001, 6'h05, 16'hffff, 15'h0001, 4'h0);
    send(16'sh8000, 6'h05, 16'hffff, 15'h7fff, 4'hf);
    drain();
  endtask : t_expounded

  task automatic t_derived();
    setmode(dzdq_pkg::DZDQ_MODE_DERIVED, 1'b1);
    send(16'sh0002, 6'h03, 16'h0040, 15'h2000, 4'h1);
    send(-16'sh0007, 6'h05, 16'h0040, 15'h2000, 4'h1);
    send(16'sh0001, 6'h09, 16'h0040, 15'h0000, 4'h2);
    send(-16'sh0001, 6'h09, 16'h0040, 15'h0000, 4'h2);
    drain();
  endtask : t_derived

  task automatic t_absent();
    setmode(dzdq_pkg::DZDQ_MODE_ABSENT, 1'b1);
    send(16'sh0000, 6'h03, 16'h0011, 15'h1000, 4'h3);
    send(16'sh0004, 6'h03, 16'h0011, 15'h1000, 4'h3);
    drain();
    setmode(dzdq_pkg::dzdq_mode_t'(2'h3), 1'b1);
    send(-16'sh0004, 6'h05, 16'h0011, 15'h1000, 4'h3);
    drain();
  endtask : t_absent

  task automatic t_reversible();
    setmode(dzdq_pkg::DZDQ_MODE_EXPOUNDED, 1'b0);
    send(16'sh0006, 6'h03, 16'h0022, 15'h0800, 4'h1);
    drain();
  endtask : t_reversible

  task automatic t_stall();
    setmode(dzdq_pkg::DZDQ_MODE_EXPOUNDED, 1'b1);
    hold <= 1'b1;
    send(16'sh0009, 6'h03, 16'h0101, 15'h0100, 4'h0);
    send(-16'sh000a, 6'h05, 16'h0202, 15'h0200, 4'h1);
    offer(16'sh000b, 6'h00, 16'h0303, 15'h0300, 4'h2);
    @(negedge clk_in);
    samples_checked++;
    if (index_ready !== 1'b0) fail("ready with buffer full");
    @(posedge clk_in);
    ce_in <= 1'b0;
    @(negedge clk_in);
    samples_checked++;
    if (coef_valid !== 1'b0 || index_ready !== 1'b0) fail("active while disabled");
    @(posedge clk_in);
    ce_in <= 1'b1;
    hold <= 1'b0;
    slow <= 1'b1;
    wait_take();
    drain();
    slow <= 1'b0;
  endtask : t_stall

  initial begin
    for (int b = 0; b < 64; b++) fac[b] = 16'sh0000;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    t_expounded();
    t_derived();
    t_absent();
    t_reversible();
    t_stall();
    close_out();
  end
endmodule : test_deadzone_dequantizer

`default_nettype wire
